// ===== hdl/pmcs_pkg.sv
// Shared constants and types for the power mode and clock sequencer.
package pmcs_pkg;

  // Clock source select codes.
  localparam logic [2:0] SRC_INTERNAL_RC = 3'h0;
  localparam logic [2:0] SRC_WATCHDOG    = 3'h1;
  localparam logic [2:0] SRC_EXT_CLOCK   = 3'h2;
  localparam logic [2:0] SRC_RTC_32K     = 3'h3;
  localparam logic [2:0] SRC_PLL         = 3'h4;
  localparam logic [2:0] SRC_RESET       = SRC_INTERNAL_RC;

  // Requested power mode codes.
  localparam logic [2:0] MODE_ACTIVE     = 3'h0;
  localparam logic [2:0] MODE_SLEEP      = 3'h1;
  localparam logic [2:0] MODE_DEEP_SLEEP = 3'h2;
  localparam logic [2:0] MODE_POWER_DOWN = 3'h3;
  localparam logic [2:0] MODE_DEEP_PD    = 3'h4;

  // Wake source bit positions.
  localparam int WAKE_PIN     = 0;
  localparam int WAKE_RTC     = 1;
  localparam int WAKE_UTICK   = 2;
  localparam int WAKE_WDOG    = 3;
  localparam int WAKE_BROWN   = 4;
  localparam int WAKE_USART   = 5;
  localparam int WAKE_SPI     = 6;
  localparam int WAKE_I2C     = 7;
  localparam int WAKE_W       = 8;

  // Debug reset restarts fetch here.
  localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;

  // Gate step spacing: one step per this many cycles in deep modes.
  localparam int STEP_NS          = 400;
  localparam int CLK_NS           = 100;
  localparam int STEP_CYCLES      = (STEP_NS + CLK_NS - 1) / CLK_NS;
  // Power down wakes slower than deep sleep.
  localparam int PD_EXTRA_STEPS   = 4;
  localparam logic [3:0] STEP_RST = 4'h0;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic src_clk_en;
    logic analog_en;
    logic flash_standby;
    logic flash_off;
    logic keep_32k;
    logic keep_watchdog_osc;
    logic keep_brownout;
    logic main_power;
  } gate_s;

  typedef enum logic [6:0] {
    ST_RUN     = 7'h01,
    ST_GATE    = 7'h02,
    ST_SLEEP   = 7'h04,
    ST_DEEP    = 7'h08,
    ST_DPD     = 7'h10,
    ST_UNGATE  = 7'h20,
    ST_RESUME  = 7'h40
  } pm_state_e;

endpackage

// ===== hdl/sync2.sv
// Two flip-flop synchroniser for a bus of asynchronous levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule

// ===== hdl/power_mode_clock_sequencer.sv
// Clock source selection, low-power mode sequencing and system safety control.
`timescale 1ns/1ps
// What this block does
// - Reset selects internal RC clock source.
// - Five selectable clock sources offered.
// - Software switches system PLL on/off.
// - Sleep, deep sleep, power down, deep power-down.
// - Sleep stops core clock only; peripheral clocks keep running.
// - Sleep wakes on enabled peripheral interrupt.
// - Deep sleep gates clocks, analog, flash standby.
// - Deep sleep wakes on listed sources.
// - Deep sleep and power down wake need both enable masks set.
// - Power down shuts analog and flash fully.
// - Power down wakes on deep sleep sources.
// - Deep modes keep state; power down slower.
// - Deep power-down wakes only by RTC.
// - Brownout sets sticky flag, irq, reset.
// - Watchdog config locked after enable.
// - Debug reset resets peripherals, restarts boot.
// - Debug pins default to debug function.
module power_mode_clock_sequencer (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // Clock configuration
  input  wire logic [2:0]                   clk_src_sel,
  input  wire logic                         clk_src_wr,
  input  wire logic                         pll_enable,
  output logic      [2:0]                   clk_src_ff,
  output logic                              pll_on_ff,
  // Power mode request
  input  wire logic [2:0]                   mode_cfg,
  input  wire logic                         keep_32k_cfg,
  input  wire logic                         keep_watchdog_osc_cfg,
  input  wire logic                         keep_brownout_cfg,
  input  wire logic                         core_sleep_req,
  output logic      [6:0]                   pm_state_ff,
  output pmcs_pkg::gate_s                   gate_ff,
  output logic                              core_wake_ff,
  // Wake sources
  input  wire logic [pmcs_pkg::WAKE_W-1:0]  wake_raw,
  input  wire logic [pmcs_pkg::WAKE_W-1:0]  wake_en_cfg,
  input  wire logic [pmcs_pkg::WAKE_W-1:0]  irq_en_ctrl,
  input  wire logic                         periph_irq,
  // Brownout monitor
  input  wire logic                         brownout_below,
  input  wire logic                         brownout_rst_lvl,
  input  wire logic                         brownout_flag_clr,
  input  wire logic                         brownout_irq_en,
  input  wire logic                         brownout_rst_en,
  output logic                              brownout_flag_ff,
  output logic                              brownout_irq_ff,
  // Windowed watchdog configuration
  input  wire logic                         wdog_cfg_wr,
  input  wire logic                         wdog_enable_wr,
  input  wire logic [23:0]                  wdog_reload_wr,
  output logic                              wdog_enabled_ff,
  output logic      [23:0]                  wdog_reload_ff,
  // Debug and resets
  input  wire logic                         debug_system_reset_request,
  output logic                              periph_reset_ff,
  output logic      [31:0]                  boot_addr_ff,
  output logic                              halt_at_entry_ff,
  output logic                              swd_pin_func_ff
);

  pmcs_pkg::pm_state_e              state_ff;
  pmcs_pkg::pm_state_e              nxt_state;
  logic [2:0]                       mode_ff;
  logic [3:0]                       step_ff;
  logic [pmcs_pkg::WAKE_W-1:0]      wake_s;
  logic [1:0]                       brown_s;
  logic                             dbg_s;
  logic                             dbg_d_ff;
  logic                             wake_hit;
  logic                             step_done;
  logic [3:0]                       step_lim;

  // Wake lines and monitor levels arrive from other domains.
  sync2 #(.W(pmcs_pkg::WAKE_W + 3)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    ({wake_raw, brownout_below, brownout_rst_lvl, debug_system_reset_request}),
    .q    ({wake_s, brown_s, dbg_s})
  );

  // Serial units only assert their wake lines in slave mode, which software arranges.
  always_comb begin
    wake_hit = 1'b0;
    unique case (mode_ff)
      pmcs_pkg::MODE_SLEEP:   wake_hit = periph_irq | (|(wake_s & irq_en_ctrl));
      pmcs_pkg::MODE_DEEP_PD: wake_hit = wake_s[pmcs_pkg::WAKE_RTC];
      default:                wake_hit = |(wake_s & wake_en_cfg & irq_en_ctrl);
    endcase
  end

  // Power down takes extra steps to come back.
  assign step_lim  = (mode_ff == pmcs_pkg::MODE_POWER_DOWN) ?
                     4'(pmcs_pkg::STEP_CYCLES + pmcs_pkg::PD_EXTRA_STEPS) :
                     4'(pmcs_pkg::STEP_CYCLES);
  assign step_done = (step_ff >= step_lim - 4'h1);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      pmcs_pkg::ST_RUN:
        if (core_sleep_req && mode_ff != pmcs_pkg::MODE_ACTIVE) begin
          nxt_state = (mode_ff == pmcs_pkg::MODE_SLEEP) ? pmcs_pkg::ST_SLEEP : pmcs_pkg::ST_GATE;
        end
      pmcs_pkg::ST_GATE:
        if (step_done) begin
          nxt_state = (mode_ff == pmcs_pkg::MODE_DEEP_PD) ? pmcs_pkg::ST_DPD : pmcs_pkg::ST_DEEP;
        end
      pmcs_pkg::ST_SLEEP:
        if (wake_hit) begin
          nxt_state = pmcs_pkg::ST_RESUME;
        end
      pmcs_pkg::ST_DEEP:
        if (wake_hit) begin
          nxt_state = pmcs_pkg::ST_UNGATE;
        end
      pmcs_pkg::ST_DPD:
        if (wake_hit) begin
          nxt_state = pmcs_pkg::ST_UNGATE;
        end
      pmcs_pkg::ST_UNGATE:
        if (step_done) begin
          nxt_state = pmcs_pkg::ST_RESUME;
        end
      pmcs_pkg::ST_RESUME:
        nxt_state = pmcs_pkg::ST_RUN;
      default:
        nxt_state = pmcs_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn || periph_reset_ff) begin
      state_ff <= pmcs_pkg::ST_RUN;
      step_ff  <= pmcs_pkg::STEP_RST;
    end else begin
      state_ff <= nxt_state;
      step_ff  <= (nxt_state != state_ff) ? pmcs_pkg::STEP_RST : step_ff + 4'h1;
    end
  end

  // The mode is latched only while running so a change mid-sequence cannot tear it.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_ff <= pmcs_pkg::MODE_ACTIVE;
    end else if (state_ff == pmcs_pkg::ST_RUN && mode_cfg <= pmcs_pkg::MODE_DEEP_PD) begin
      mode_ff <= mode_cfg;
    end
  end

  // Gating: core clock drops first, power and flash last; wake reverses that order.
  // A peripheral reset also reopens every gate, since it forces the sequence back to run.
  always_ff @(posedge clk) begin
    if (!rstn || periph_reset_ff) begin
      gate_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    end else begin
      unique case (nxt_state)
        pmcs_pkg::ST_SLEEP: begin
          gate_ff.core_clk_en <= 1'b0;
        end
        pmcs_pkg::ST_GATE: begin
          gate_ff.core_clk_en   <= 1'b0;
          gate_ff.periph_clk_en <= 1'b0;
        end
        pmcs_pkg::ST_DEEP: begin
          gate_ff.src_clk_en    <= 1'b0;
          gate_ff.analog_en     <= 1'b0;
          gate_ff.flash_standby <= (mode_ff == pmcs_pkg::MODE_DEEP_SLEEP);
          gate_ff.flash_off     <= (mode_ff == pmcs_pkg::MODE_POWER_DOWN);
          gate_ff.keep_32k      <= keep_32k_cfg;
          gate_ff.keep_watchdog_osc    <= keep_watchdog_osc_cfg;
          gate_ff.keep_brownout <= keep_brownout_cfg;
        end
        pmcs_pkg::ST_DPD: begin
          gate_ff.src_clk_en    <= 1'b0;
          gate_ff.analog_en     <= 1'b0;
          gate_ff.flash_off     <= 1'b1;
          gate_ff.keep_32k      <= 1'b1;
          gate_ff.keep_watchdog_osc    <= 1'b0;
          gate_ff.keep_brownout <= 1'b0;
          gate_ff.main_power    <= 1'b0;
        end
        pmcs_pkg::ST_UNGATE: begin
          gate_ff.main_power    <= 1'b1;
          gate_ff.src_clk_en    <= 1'b1;
          gate_ff.analog_en     <= 1'b1;
          gate_ff.flash_standby <= 1'b0;
          gate_ff.flash_off     <= 1'b0;
          gate_ff.keep_32k      <= 1'b1;
          gate_ff.keep_watchdog_osc    <= 1'b1;
          gate_ff.keep_brownout <= 1'b1;
        end
        pmcs_pkg::ST_RESUME: begin
          gate_ff.periph_clk_en <= 1'b1;
          gate_ff.core_clk_en   <= 1'b1;
        end
        default: begin
          gate_ff <= gate_ff;
        end
      endcase
    end
  end

  // Follows the state register through every reset so the visible state never drifts.
  always_ff @(posedge clk) begin
    if (!rstn || periph_reset_ff) begin
      core_wake_ff <= 1'b0;
      pm_state_ff  <= pmcs_pkg::ST_RUN;
    end else begin
      core_wake_ff <= (nxt_state == pmcs_pkg::ST_RESUME);
      pm_state_ff  <= nxt_state;
    end
  end

  // Clock source: any reset returns to the internal RC oscillator.
  always_ff @(posedge clk) begin
    if (!rstn || periph_reset_ff) begin
      clk_src_ff <= pmcs_pkg::SRC_RESET;
      pll_on_ff  <= 1'b0;
    end else begin
      pll_on_ff <= pll_enable;
      if (clk_src_wr && clk_src_sel <= pmcs_pkg::SRC_PLL) begin
        clk_src_ff <= clk_src_sel;
      end
    end
  end

  // A new drop below the fixed level wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      brownout_flag_ff <= 1'b0;
      brownout_irq_ff  <= 1'b0;
    end else begin
      if (brown_s[1]) begin
        brownout_flag_ff <= 1'b1;
      end else if (brownout_flag_clr) begin
        brownout_flag_ff <= 1'b0;
      end
      brownout_irq_ff <= brownout_irq_en & (brown_s[1] | brownout_flag_ff);
    end
  end

  // Once enabled, the watchdog ignores all configuration until reset.
  always_ff @(posedge clk) begin
    if (!rstn || periph_reset_ff) begin
      wdog_enabled_ff <= 1'b0;
      wdog_reload_ff  <= 24'hFFFFFF;
    end else if (wdog_cfg_wr && !wdog_enabled_ff) begin
      wdog_enabled_ff <= wdog_enable_wr;
      wdog_reload_ff  <= wdog_reload_wr;
    end
  end

  // Debug reset pulses peripheral reset and restarts boot, halting at entry; brownout reset holds peripheral reset while its level stays set.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dbg_d_ff         <= 1'b0;
      periph_reset_ff  <= 1'b0;
      boot_addr_ff     <= pmcs_pkg::BOOT_ADDR;
      halt_at_entry_ff <= 1'b0;
      swd_pin_func_ff  <= 1'b1;
    end else begin
      dbg_d_ff        <= dbg_s;
      periph_reset_ff <= (dbg_s & ~dbg_d_ff) | (brownout_rst_en & brown_s[0]);
      boot_addr_ff    <= pmcs_pkg::BOOT_ADDR;
      if (dbg_s & ~dbg_d_ff) begin
        halt_at_entry_ff <= 1'b1;
      end else if (core_sleep_req) begin
        halt_at_entry_ff <= halt_at_entry_ff;
      end
      if (periph_reset_ff) begin
        swd_pin_func_ff <= 1'b1;
      end
    end
  end

  // Assertions.
  a_reset_src_irc: assert property (@(posedge clk) disable iff (!rstn)
    periph_reset_ff |=> clk_src_ff == pmcs_pkg::SRC_RESET)
    else $error("clock source not internal RC after reset");
  a_sleep_core_off: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == pmcs_pkg::ST_SLEEP |-> !gate_ff.core_clk_en)
    else $error("core clock running in sleep");
  a_deep_gates: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == pmcs_pkg::ST_DEEP |-> !gate_ff.analog_en && !gate_ff.src_clk_en)
    else $error("analog or sources on in deep mode");
  a_wdog_locked: assert property (@(posedge clk) disable iff (!rstn || periph_reset_ff)
    wdog_enabled_ff && !periph_reset_ff |=>
    wdog_enabled_ff && $stable(wdog_reload_ff))
    else $error("watchdog config changed after enable");
  a_brown_sticky: assert property (@(posedge clk) disable iff (!rstn)
    brown_s[1] |=> brownout_flag_ff)
    else $error("brownout flag not set");
  a_dpd_rtc_only: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == pmcs_pkg::ST_DPD && !wake_s[pmcs_pkg::WAKE_RTC] |=> state_ff == pmcs_pkg::ST_DPD)
    else $error("deep power-down left without RTC");
  a_dbg_reset: assert property (@(posedge clk) disable iff (!rstn)
    dbg_s && !dbg_d_ff |=> periph_reset_ff && boot_addr_ff == pmcs_pkg::BOOT_ADDR)
    else $error("debug reset did not reset peripherals");
  a_wake_resume: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == pmcs_pkg::ST_SLEEP && wake_hit |=> state_ff == pmcs_pkg::ST_RESUME ##1 gate_ff.core_clk_en)
    else $error("sleep wake did not resume core");
  a_sleep_entry: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == pmcs_pkg::ST_RUN && core_sleep_req && mode_ff == pmcs_pkg::MODE_ACTIVE |=> state_ff == pmcs_pkg::ST_RUN)
    else $error("low-power entry while mode active");
  c_sleep: cover property (@(posedge clk) state_ff == pmcs_pkg::ST_SLEEP);
  c_deep_wake: cover property (@(posedge clk) state_ff == pmcs_pkg::ST_DEEP ##1 state_ff == pmcs_pkg::ST_UNGATE);
  c_dpd: cover property (@(posedge clk) state_ff == pmcs_pkg::ST_DPD);
  c_wdog_lock: cover property (@(posedge clk) wdog_enabled_ff && wdog_cfg_wr);

endmodule

// ===== verif/core_wake_model.sv
// Core and wake-source model facing the sequencer.
`timescale 1ns/1ps
module core_wake_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Commands from the bench
  input  wire logic       go,
  input  wire logic       fire,
  input  wire logic [7:0] wake_sel,
  input  wire logic       slave_cfg,
  // Sequencer side
  input  wire logic       core_wake_ff,
  output logic            core_sleep_req,
  output logic      [7:0] wake_raw,
  output logic            periph_irq
);
  logic [7:0] serial_mask;
  // Serial units only signal a wake when they are set up as slaves.
  assign serial_mask = slave_cfg ? 8'hFF : 8'h1F;
  always @(negedge clk) begin
    if (!rstn) begin
      core_sleep_req <= 1'b0;
      wake_raw <= 8'h00;
      periph_irq <= 1'b0;
    end else if (core_wake_ff) begin
      // Dropped while resuming, so the core does not fall straight back asleep.
      core_sleep_req <= 1'b0;
      wake_raw <= 8'h00;
      periph_irq <= 1'b0;
    end else begin
      if (go) core_sleep_req <= 1'b1;
      if (fire) begin
        wake_raw <= wake_sel & serial_mask;
        periph_irq <= (wake_sel == 8'h00);
      end
    end
  end
endmodule

// ===== verif/power_mode_clock_sequencer_tb.sv
// Self-checking bench for the power mode and clock sequencer.
`timescale 1ns/1ps
module power_mode_clock_sequencer_tb;
  logic clk, rstn, clk_src_wr, pll_enable, pll_on_ff, keep_32k_cfg, keep_watchdog_osc_cfg;
  logic keep_brownout_cfg, core_sleep_req, core_wake_ff, periph_irq, go, fire, slave_cfg;
  logic brownout_below, brownout_rst_lvl, brownout_flag_clr, brownout_irq_en;
  logic brownout_rst_en, brownout_flag_ff, brownout_irq_ff, wdog_cfg_wr, wdog_enable_wr;
  logic wdog_enabled_ff, debug_system_reset_request, periph_reset_ff;
  logic halt_at_entry_ff, swd_pin_func_ff;
  logic [2:0]  clk_src_sel, mode_cfg, clk_src_ff;
  logic [6:0]  pm_state_ff;
  logic [7:0]  wake_raw, wake_en_cfg, irq_en_ctrl, wake_sel;
  logic [23:0] wdog_reload_wr, wdog_reload_ff;
  logic [31:0] boot_addr_ff;
  pmcs_pkg::gate_s gate_ff, g;
  int err_count, tests_run, nd, np, n;

  power_mode_clock_sequencer i_dut (
    .clk, .rstn, .clk_src_sel, .clk_src_wr, .pll_enable, .clk_src_ff, .pll_on_ff,
    .mode_cfg, .keep_32k_cfg, .keep_watchdog_osc_cfg, .keep_brownout_cfg, .core_sleep_req,
    .pm_state_ff, .gate_ff, .core_wake_ff, .wake_raw, .wake_en_cfg, .irq_en_ctrl,
    .periph_irq, .brownout_below, .brownout_rst_lvl, .brownout_flag_clr,
    .brownout_irq_en, .brownout_rst_en, .brownout_flag_ff, .brownout_irq_ff,
    .wdog_cfg_wr, .wdog_enable_wr, .wdog_reload_wr, .wdog_enabled_ff, .wdog_reload_ff,
    .debug_system_reset_request, .periph_reset_ff, .boot_addr_ff, .halt_at_entry_ff,
    .swd_pin_func_ff
  );

  core_wake_model i_model (
    .clk, .rstn, .go, .fire, .wake_sel, .slave_cfg, .core_wake_ff, .core_sleep_req,
    .wake_raw, .periph_irq
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_rst;
    n = 0;
    while (periph_reset_ff !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk("periph_reset_ff", 1, periph_reset_ff);
  endtask

  // Enter a mode, fire a wake source; when blk is set the first wake must be refused.
  task automatic lp(input logic [2:0] m, input logic [7:0] s, input logic blk,
                    output int cyc);
    logic [6:0] st;
    st = (m == pmcs_pkg::MODE_DEEP_PD) ? pmcs_pkg::ST_DPD :
         (m == pmcs_pkg::MODE_SLEEP) ? pmcs_pkg::ST_SLEEP : pmcs_pkg::ST_DEEP;
    mode_cfg <= m;
    wake_sel <= s;
    tick(1);
    go <= 1'b1;
    tick(1);
    go <= 1'b0;
    tick(1);
    cyc = 0;
    while (m != pmcs_pkg::MODE_SLEEP && pm_state_ff !== st && cyc < 10) begin
      tick(1);
      cyc++;
    end
    chk("pm_state_ff entry", st, pm_state_ff);
    g = gate_ff;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    if (blk) begin
      tick(20);
      chk("pm_state_ff held", st, pm_state_ff);
      irq_en_ctrl <= 8'hFF;
      slave_cfg <= 1'b1;
      wake_sel <= 8'h01 << pmcs_pkg::WAKE_RTC;
      fire <= 1'b1;
      tick(1);
      fire <= 1'b0;
    end
    cyc = 1;
    while (pm_state_ff !== pmcs_pkg::ST_RESUME && cyc < 40) begin
      tick(1);
      cyc++;
    end
    chk("core_wake_ff", 1, core_wake_ff);
    tick(1);
    chk("pm_state_ff run", pmcs_pkg::ST_RUN, pm_state_ff);
    chk("core_clk_en", 1, gate_ff.core_clk_en);
  endtask

  initial begin
    {rstn, clk_src_wr, pll_enable, keep_watchdog_osc_cfg, keep_brownout_cfg, go, fire} = '0;
    {brownout_below, brownout_rst_lvl, brownout_flag_clr, brownout_irq_en} = '0;
    {brownout_rst_en, wdog_cfg_wr, wdog_enable_wr, debug_system_reset_request} = '0;
    {clk_src_sel, mode_cfg, wake_sel, wdog_reload_wr} = '0;
    {keep_32k_cfg, slave_cfg, wake_en_cfg, irq_en_ctrl} = {1'b1, 1'b1, 8'hFF, 8'hFF};
    err_count = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rstn <= 1'b1;
    tick(1);
    chk("clk_src_ff reset", pmcs_pkg::SRC_INTERNAL_RC, clk_src_ff);
    chk("gate_ff reset", 10'h3CF, gate_ff);
    chk("pm_state_ff reset", pmcs_pkg::ST_RUN, pm_state_ff);
    chk("swd_pin_func_ff", 1, swd_pin_func_ff);
    chk("wdog_reload_ff reset", 24'hFFFFFF, wdog_reload_ff);
    chk("pll_on_ff reset", 0, pll_on_ff);
    // Code 5 is out of range and must leave the PLL selection in place.
    for (int i = 0; i < 6; i++) begin
      clk_src_sel <= i[2:0];
      clk_src_wr <= 1'b1;
      tick(1);
      clk_src_wr <= 1'b0;
      tick(1);
      chk("clk_src_ff", (i > 4) ? 4 : i, clk_src_ff);
    end
    pll_enable <= 1'b1;
    tick(2);
    chk("pll_on_ff on", 1, pll_on_ff);
    pll_enable <= 1'b0;
    tick(2);
    chk("pll_on_ff off", 0, pll_on_ff);
    lp(pmcs_pkg::MODE_SLEEP, 8'h00, 1'b0, n);
    chk("sleep core_clk_en", 0, g.core_clk_en);
    for (int b = 0; b < 8; b++) lp(pmcs_pkg::MODE_DEEP_SLEEP, 8'h01 << b, 1'b0, nd);
    chk("deep analog_en", 0, g.analog_en);
    chk("deep flash_standby", 1, g.flash_standby);
    chk("deep src_clk_en", 0, g.src_clk_en);
    chk("deep keep_32k", 1, g.keep_32k);
    for (int b = 0; b < 8; b++) lp(pmcs_pkg::MODE_POWER_DOWN, 8'h01 << b, 1'b0, np);
    chk("pd flash_off", 1, g.flash_off);
    chk("pd analog_en", 0, g.analog_en);
    chk("pd extra wake cycles", pmcs_pkg::PD_EXTRA_STEPS, np - nd);
    irq_en_ctrl <= 8'hFE;
    lp(pmcs_pkg::MODE_DEEP_SLEEP, 8'h01, 1'b1, n);
    wake_en_cfg <= 8'hFE;
    lp(pmcs_pkg::MODE_DEEP_SLEEP, 8'h01, 1'b1, n);
    wake_en_cfg <= 8'hFF;
    slave_cfg <= 1'b0;
    lp(pmcs_pkg::MODE_POWER_DOWN, 8'h20, 1'b1, n);
    lp(pmcs_pkg::MODE_DEEP_PD, 8'h01, 1'b1, n);
    chk("dpd main_power", 0, g.main_power);
    brownout_irq_en <= 1'b1;
    brownout_below <= 1'b1;
    tick(4);
    chk("brownout_flag_ff", 1, brownout_flag_ff);
    chk("brownout_irq_ff", 1, brownout_irq_ff);
    brownout_below <= 1'b0;
    tick(3);
    brownout_flag_clr <= 1'b1;
    tick(1);
    brownout_flag_clr <= 1'b0;
    tick(2);
    chk("brownout_flag_ff clear", 0, brownout_flag_ff);
    chk("brownout_irq_ff clear", 0, brownout_irq_ff);
    brownout_rst_en <= 1'b1;
    brownout_rst_lvl <= 1'b1;
    wait_rst();
    brownout_rst_lvl <= 1'b0;
    tick(4);
    chk("clk_src_ff after reset", pmcs_pkg::SRC_INTERNAL_RC, clk_src_ff);
    wdog_enable_wr <= 1'b1;
    wdog_reload_wr <= 24'h001234;
    for (int k = 0; k < 2; k++) begin
      wdog_cfg_wr <= 1'b1;
      tick(1);
      wdog_cfg_wr <= 1'b0;
      tick(1);
      chk("wdog_enabled_ff", 1, wdog_enabled_ff);
      chk("wdog_reload_ff", 24'h001234, wdog_reload_ff);
      wdog_enable_wr <= 1'b0;
      wdog_reload_wr <= 24'hABCDEF;
    end
    debug_system_reset_request <= 1'b1;
    wait_rst();
    chk("boot_addr_ff", pmcs_pkg::BOOT_ADDR, boot_addr_ff);
    tick(2);
    chk("halt_at_entry_ff", 1, halt_at_entry_ff);
    chk("wdog_enabled_ff after reset", 0, wdog_enabled_ff);
    debug_system_reset_request <= 1'b0;
    results();
  end

  // The whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end
endmodule
